// ===== verilog/eec_pkg.sv
// Constants for the feature enhancement enable register bank.
// Assumes one 40 MHz system clock and an APB register port.
package eec_pkg;

  // Clock rate
  localparam int unsigned CLK_HZ = 40_000_000;

  // Register byte addresses
  localparam logic [7:0] ADDR_FEATURE_ENH = 8'h6c;
  localparam logic [7:0] ADDR_LINE_CTRL   = 8'h80;
  localparam logic [7:0] ADDR_LIMIT_VALUE = 8'h84;
  localparam logic [7:0] ADDR_STATUS      = 8'h88;

  // Reset values
  localparam logic [7:0] RST_FEATURE_ENH = 8'h00;
  localparam logic [7:0] RST_LINE_CTRL   = 8'h00;
  localparam logic [7:0] RST_LIMIT_VALUE = 8'h14;

  // Enhancement register fields
  localparam int BIT_CURRENT_BOOST = 7;
  localparam int BIT_TONE_SPEEDUP  = 6;
  localparam int BIT_CONV_FAST     = 5;
  localparam int BIT_EXT_IMPEDANCE = 4;
  localparam int BIT_BATT_DEBOUNCE = 3;
  localparam int BIT_VOLT_CLOSURE  = 2;
  localparam int BIT_DC_FILTER     = 1;
  localparam int BIT_HYSTERESIS    = 0;

  // Implemented bits per variant
  localparam logic [7:0] MASK_SUPPLY_GEN = 8'hf7;
  localparam logic [7:0] MASK_SUPPLY_SEL = 8'hdd;

  // Line control register fields
  localparam int BIT_RELAY_CTRL = 6;

  // Status register fields
  localparam int BIT_ST_BOOST  = 0;
  localparam int BIT_ST_FAST   = 1;
  localparam int BIT_ST_CLOSED = 2;
  localparam int BIT_ST_BATT_H = 3;

  // Boosted differential loop current limit in mA
  localparam logic [7:0] BOOST_LIMIT_MA = 8'd41;

  // Tone generator rates and derived tick periods
  localparam int unsigned TONE_BASE_HZ  = 8_000;
  localparam int unsigned TONE_FAST_HZ  = 24_000;
  localparam int unsigned TONE_BASE_CYC = CLK_HZ / TONE_BASE_HZ;
  localparam int unsigned TONE_FAST_CYC = (CLK_HZ + TONE_FAST_HZ - 1) / TONE_FAST_HZ;

  // Battery switch debounce and boost hold times in ms
  localparam int unsigned DEBOUNCE_MS    = 60;
  localparam int unsigned BOOST_HOLD_MS  = 10;
  localparam int unsigned DEBOUNCE_CYC   = DEBOUNCE_MS * (CLK_HZ / 1000);
  localparam int unsigned BOOST_HOLD_CYC = BOOST_HOLD_MS * (CLK_HZ / 1000);

  // Width of the long timers
  localparam int TIMER_W = 24;

endpackage : eec_pkg

// ===== verilog/eec_tick_div.sv
// Programmable divider giving a one-cycle enable pulse.
// Assumes the period input is at least one and changes only rarely.
`timescale 1ns/1ps
module eec_tick_div #(
  parameter int CNT_W = 16
) (
  // Clock and reset
  input  wire logic             clk_sys,
  input  wire logic             sys_rst,
  // Period in clock cycles
  input  wire logic [CNT_W-1:0] period,
  // Enable pulse
  output logic                  tick
);

  logic [CNT_W-1:0] count;

  // Counts down and restarts from the current period
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      count <= '0;
      tick  <= 1'b0;
    end else if (count == '0) begin
      count <= period - 1'b1;
      tick  <= 1'b1;
    end else begin
      count <= (count >= period) ? period - 1'b1 : count - 1'b1;
      tick  <= 1'b0;
    end
  end

endmodule : eec_tick_div

// ===== verilog/eec_enhance_ctrl.sv
// Feature enhancement enable register and the control it steers.
// Assumes an APB master on clk_sys and line status inputs synchronous to it.
//
// What this block does
// - Boost off: use programmed loop current limit
// - Boost on: limit raised to 41 mA after ring
// - Speedup and relay set: tone clocked 24 kHz
// - Enhanced FSK uses dedicated oscillator registers
// - Enhanced FSK: cadence timers step 41.67 us
// - Speedup clear: 8 kHz, standard oscillator registers
// - Converter bit selects multi-threshold control algorithm
// - Converter bit only in self-supply variant
// - Loop closure from voltage or current
// - Selection variant: 60 ms debounce high-to-low
//
// Implementation choice: the APB interface to the registers.
`timescale 1ns/1ps
module eec_enhance_ctrl
  import eec_pkg::*;
#(
  parameter bit          SUPPLY_GEN     = 1'b1,
  parameter int unsigned BASE_CYC       = TONE_BASE_CYC,
  parameter int unsigned FAST_CYC       = TONE_FAST_CYC,
  parameter int unsigned DEBOUNCE_CYCLES = DEBOUNCE_CYC,
  parameter int unsigned BOOST_CYCLES   = BOOST_HOLD_CYC
) (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Line events and levels
  input  wire logic        ring_burst_end,
  input  wire logic        loop_current_closed,
  input  wire logic        loop_voltage_closed,
  input  wire logic        battery_high_request,
  // Line feed control
  output logic [7:0]       loop_current_limit_ma,
  output logic             loop_closed,
  output logic             battery_high_select,
  // Tone generator control
  output logic             tone_tick,
  output logic             tone_fast_mode,
  output logic             tone_osc_one_fsk_set,
  output logic             osc_one_cadence_tick,
  // Analog option controls
  output logic             converter_fast_control,
  output logic             external_impedance_reference,
  output logic             dc_filter_select,
  output logic             hysteresis_select
);

  localparam logic [7:0] IMPL_MASK = SUPPLY_GEN ? MASK_SUPPLY_GEN : MASK_SUPPLY_SEL;
  localparam logic [15:0] BASE_P = 16'(BASE_CYC);
  localparam logic [15:0] FAST_P = 16'(FAST_CYC);
  localparam logic [TIMER_W-1:0] DEB_P   = TIMER_W'(DEBOUNCE_CYCLES);
  localparam logic [TIMER_W-1:0] BOOST_P = TIMER_W'(BOOST_CYCLES);

  logic [7:0]         feature_enhancement_enables;
  logic [7:0]         line_ctrl;
  logic [7:0]         limit_value;
  logic [TIMER_W-1:0] boost_timer;
  logic [TIMER_W-1:0] deb_timer;
  logic               boost_active;
  logic               fsk_enh;
  logic               wr_en;
  logic               setup;
  logic               mapped;
  logic [7:0]         next_rdata;
  logic [7:0]         status;

  // Address decode shared by write and error paths
  function automatic logic is_mapped(input logic [7:0] a);
    return (a == ADDR_FEATURE_ENH) || (a == ADDR_LINE_CTRL) ||
           (a == ADDR_LIMIT_VALUE) || (a == ADDR_STATUS);
  endfunction : is_mapped

  // APB handshake, zero wait states
  assign setup   = psel & ~penable;
  assign mapped  = is_mapped(paddr);
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~mapped;
  assign wr_en   = psel & penable & pwrite & mapped;

  // Register writes, unimplemented bits held at zero
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      feature_enhancement_enables <= RST_FEATURE_ENH;
    end else if (wr_en && paddr == ADDR_FEATURE_ENH) begin
      feature_enhancement_enables <= pwdata[7:0] & IMPL_MASK;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      line_ctrl   <= RST_LINE_CTRL;
      limit_value <= RST_LIMIT_VALUE;
    end else if (wr_en) begin
      if (paddr == ADDR_LINE_CTRL) begin
        line_ctrl <= pwdata[7:0] & (8'h01 << BIT_RELAY_CTRL);
      end
      if (paddr == ADDR_LIMIT_VALUE) begin
        limit_value <= pwdata[7:0];
      end
    end
  end

  // Read data captured in the setup cycle
  assign status = {4'h0, battery_high_select, loop_closed, tone_fast_mode, boost_active};

  always_comb begin
    next_rdata = 8'h00;
    if (paddr == ADDR_FEATURE_ENH) begin
      next_rdata = feature_enhancement_enables;
    end else if (paddr == ADDR_LINE_CTRL) begin
      next_rdata = line_ctrl;
    end else if (paddr == ADDR_LIMIT_VALUE) begin
      next_rdata = limit_value;
    end else if (paddr == ADDR_STATUS) begin
      next_rdata = status;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      prdata <= 32'h0000_0000;
    end else if (setup && !pwrite) begin
      prdata <= {24'h00_0000, next_rdata};
    end
  end

  // Temporary current limit boost after each ring burst
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      boost_timer <= '0;
    end else if (!feature_enhancement_enables[BIT_CURRENT_BOOST]) begin
      boost_timer <= '0;
    end else if (ring_burst_end) begin
      boost_timer <= BOOST_P;
    end else if (boost_timer != '0) begin
      boost_timer <= boost_timer - 1'b1;
    end
  end

  assign boost_active = (boost_timer != '0);

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      loop_current_limit_ma <= RST_LIMIT_VALUE;
    end else begin
      loop_current_limit_ma <= boost_active ? BOOST_LIMIT_MA : limit_value;
    end
  end

  // Tone generator rate and oscillator set selection
  assign fsk_enh = feature_enhancement_enables[BIT_TONE_SPEEDUP] & line_ctrl[BIT_RELAY_CTRL];

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      tone_fast_mode       <= 1'b0;
      tone_osc_one_fsk_set <= 1'b0;
    end else begin
      tone_fast_mode       <= fsk_enh;
      tone_osc_one_fsk_set <= fsk_enh;
    end
  end

  eec_tick_div #(
    .CNT_W (16)
  ) u_tone_div (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .period  (tone_fast_mode ? FAST_P : BASE_P),
    .tick    (tone_tick)
  );

  // Cadence timers step on the tone tick, finer in fast mode
  assign osc_one_cadence_tick = tone_tick;

  // Analog option bits
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      converter_fast_control       <= 1'b0;
      external_impedance_reference <= 1'b0;
      dc_filter_select             <= 1'b0;
      hysteresis_select            <= 1'b0;
    end else begin
      converter_fast_control       <= feature_enhancement_enables[BIT_CONV_FAST];
      external_impedance_reference <= feature_enhancement_enables[BIT_EXT_IMPEDANCE];
      dc_filter_select             <= feature_enhancement_enables[BIT_DC_FILTER];
      hysteresis_select            <= feature_enhancement_enables[BIT_HYSTERESIS];
    end
  end

  // Loop closure source
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      loop_closed <= 1'b0;
    end else if (feature_enhancement_enables[BIT_VOLT_CLOSURE]) begin
      loop_closed <= loop_voltage_closed;
    end else begin
      loop_closed <= loop_current_closed;
    end
  end

  // Battery select, debounced only from high to low
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      battery_high_select <= 1'b1;
      deb_timer           <= '0;
    end else if (battery_high_request) begin
      battery_high_select <= 1'b1;
      deb_timer           <= '0;
    end else if (!battery_high_select) begin
      deb_timer <= '0;
    end else if (!feature_enhancement_enables[BIT_BATT_DEBOUNCE]) begin
      battery_high_select <= 1'b0;
      deb_timer           <= '0;
    end else if (deb_timer >= DEB_P - 1'b1) begin
      battery_high_select <= 1'b0;
      deb_timer           <= '0;
    end else begin
      deb_timer <= deb_timer + 1'b1;
    end
  end

endmodule : eec_enhance_ctrl

// ===== verification/eec_enhance_ctrl_asserts.sv
// Port assertions for the enhancement control block.
// Assumes a bind into eec_enhance_ctrl and an APB master keeping the protocol.
`timescale 1ns/1ps
module eec_enhance_ctrl_asserts
  import eec_pkg::*;
(
  // Clock and reset
  input wire logic        clk_sys,
  input wire logic        sys_rst,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Line side
  input wire logic        ring_burst_end,
  input wire logic        battery_high_request,
  input wire logic [7:0]  loop_current_limit_ma,
  input wire logic        battery_high_select,
  // Tone and options
  input wire logic        tone_tick,
  input wire logic        tone_fast_mode,
  input wire logic        tone_osc_one_fsk_set,
  input wire logic        osc_one_cadence_tick,
  input wire logic        converter_fast_control,
  input wire logic        external_impedance_reference,
  input wire logic        dc_filter_select,
  input wire logic        hysteresis_select
);
  logic wr_enh;
  logic mapped;
  logic boost_en;
  assign wr_enh = psel && penable && pwrite && paddr == ADDR_FEATURE_ENH;
  assign mapped = paddr inside {ADDR_FEATURE_ENH, ADDR_LINE_CTRL, ADDR_LIMIT_VALUE, ADDR_STATUS};
  // Shadow of the boost enable bit
  always_ff @(posedge clk_sys) begin
    if (sys_rst) boost_en <= 1'b0;
    else if (wr_enh) boost_en <= pwdata[BIT_CURRENT_BOOST];
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  a_ready_high: assert property (pready) else $error("pready low");
  a_access_err: assert property (psel && penable |-> pslverr == !mapped)
    else $error("pslverr wrong in access");
  a_idle_err: assert property (!(psel && penable) |-> !pslverr) else $error("stray pslverr");
  a_option_copy: assert property (wr_enh |-> ##2 {converter_fast_control,
    external_impedance_reference, dc_filter_select, hysteresis_select}
    == $past({pwdata[5], pwdata[4], pwdata[1], pwdata[0]}, 2)) else $error("option copy");
  a_tick_pair: assert property (tone_tick == osc_one_cadence_tick) else $error("cadence tick");
  a_tick_gap: assert property (tone_tick |=> !tone_tick [*2]) else $error("tick too close");
  a_fsk_pair: assert property (tone_osc_one_fsk_set == tone_fast_mode) else $error("fsk set");
  a_boost_start: assert property (ring_burst_end && boost_en |-> ##2
    loop_current_limit_ma == BOOST_LIMIT_MA) else $error("no boost");
  a_batt_rise: assert property (battery_high_request |=> battery_high_select)
    else $error("battery select");
  a_reset_clear: assert property (disable iff (1'b0) sys_rst |=> !converter_fast_control
    && loop_current_limit_ma == RST_LIMIT_VALUE) else $error("reset values");
  c_write: cover property (wr_enh);
  c_fast: cover property (tone_fast_mode && tone_tick);
  c_boost: cover property (loop_current_limit_ma == BOOST_LIMIT_MA);
endmodule : eec_enhance_ctrl_asserts
bind eec_enhance_ctrl eec_enhance_ctrl_asserts u_asserts (
  .clk_sys                      (clk_sys),
  .sys_rst                      (sys_rst),
  .psel                         (psel),
  .penable                      (penable),
  .pwrite                       (pwrite),
  .paddr                        (paddr),
  .pwdata                       (pwdata),
  .pready                       (pready),
  .pslverr                      (pslverr),
  .ring_burst_end               (ring_burst_end),
  .battery_high_request         (battery_high_request),
  .loop_current_limit_ma        (loop_current_limit_ma),
  .battery_high_select          (battery_high_select),
  .tone_tick                    (tone_tick),
  .tone_fast_mode               (tone_fast_mode),
  .tone_osc_one_fsk_set         (tone_osc_one_fsk_set),
  .osc_one_cadence_tick         (osc_one_cadence_tick),
  .converter_fast_control       (converter_fast_control),
  .external_impedance_reference (external_impedance_reference),
  .dc_filter_select             (dc_filter_select),
  .hysteresis_select            (hysteresis_select)
);

// ===== verification/eec_enhance_ctrl_bench.sv
// Self-checking bench for the enhancement control block.
// Assumes the self-supply variant with shortened counts.
`timescale 1ns/1ps
module eec_enhance_ctrl_bench;
  import eec_pkg::*;
  logic clk_sys = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 0, d, loop_current_limit_ma;
  logic [31:0] pwdata = 0, prdata, rdv;
  logic pready, pslverr, err, ring_burst_end = 0, loop_current_closed = 0;
  logic loop_voltage_closed = 0, battery_high_request = 1, loop_closed, battery_high_select;
  logic tone_tick, tone_fast_mode, tone_osc_one_fsk_set, osc_one_cadence_tick;
  logic converter_fast_control, external_impedance_reference, dc_filter_select;
  logic hysteresis_select;
  int miscompares = 0, n_compared = 0, cyc = 0, c;
  logic [2:0] i;
  eec_enhance_ctrl #(.BASE_CYC(8), .FAST_CYC(3), .DEBOUNCE_CYCLES(20), .BOOST_CYCLES(10))
    DUT (
    .clk_sys                      (clk_sys),
    .sys_rst                      (sys_rst),
    .psel                         (psel),
    .penable                      (penable),
    .pwrite                       (pwrite),
    .paddr                        (paddr),
    .pwdata                       (pwdata),
    .prdata                       (prdata),
    .pready                       (pready),
    .pslverr                      (pslverr),
    .ring_burst_end               (ring_burst_end),
    .loop_current_closed          (loop_current_closed),
    .loop_voltage_closed          (loop_voltage_closed),
    .battery_high_request         (battery_high_request),
    .loop_current_limit_ma        (loop_current_limit_ma),
    .loop_closed                  (loop_closed),
    .battery_high_select          (battery_high_select),
    .tone_tick                    (tone_tick),
    .tone_fast_mode               (tone_fast_mode),
    .tone_osc_one_fsk_set         (tone_osc_one_fsk_set),
    .osc_one_cadence_tick         (osc_one_cadence_tick),
    .converter_fast_control       (converter_fast_control),
    .external_impedance_reference (external_impedance_reference),
    .dc_filter_select             (dc_filter_select),
    .hysteresis_select            (hysteresis_select)
  );
  always #12.5 clk_sys = !clk_sys;
  task automatic give_verdict;
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : give_verdict
  always @(posedge clk_sys) if (++cyc > 5000) begin
    miscompares++;
    give_verdict;
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] %s exp %h got %h", n, e, g);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_sys);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, v};
    @(posedge clk_sys);
    penable <= 1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    rdv = prdata;
    err = pslverr;
    {psel, penable} <= 2'b00;
  endtask : apb
  task automatic gap;
    do @(posedge clk_sys); while (tone_tick !== 1'b1);
    c = 0;
    do begin @(posedge clk_sys); c++; end while (tone_tick !== 1'b1);
  endtask : gap
  task automatic pulse;
    @(posedge clk_sys) ring_burst_end <= 1;
    @(posedge clk_sys) ring_burst_end <= 0;
    repeat (3) @(posedge clk_sys);
  endtask : pulse
  initial begin
    void'($urandom(32'h96338d3a));
    repeat (2) @(posedge clk_sys);
    sys_rst <= 0;
    apb(0, ADDR_FEATURE_ENH, 0); chk("enh", RST_FEATURE_ENH, rdv);
    apb(0, ADDR_LIMIT_VALUE, 0); chk("lim", RST_LIMIT_VALUE, rdv);
    apb(0, 8'h10, 0); chk("unmapped", 1, err);
    for (int k = 0; k < 9; k++) begin
      d = (k == 0) ? 8'hff : 8'($urandom);
      apb(1, ADDR_FEATURE_ENH, {24'h0, d});
      apb(0, ADDR_FEATURE_ENH, 0);
      chk("readback", d & MASK_SUPPLY_GEN, rdv);
      chk("conv", d[5], converter_fast_control);
      chk("ext", d[BIT_EXT_IMPEDANCE], external_impedance_reference);
      chk("dcfilt", d[BIT_DC_FILTER], dc_filter_select);
      chk("hyst", d[BIT_HYSTERESIS], hysteresis_select);
    end
    d = 8'd20 + 8'($urandom % 20);
    apb(1, ADDR_LIMIT_VALUE, {24'h0, d});
    apb(1, ADDR_FEATURE_ENH, 0);
    pulse; chk("noboost", d, loop_current_limit_ma);
    apb(1, ADDR_FEATURE_ENH, 32'h80);
    pulse; chk("boost", BOOST_LIMIT_MA, loop_current_limit_ma);
    repeat (10) @(posedge clk_sys);
    chk("boost end", d, loop_current_limit_ma);
    apb(1, ADDR_FEATURE_ENH, 32'h80);
    pulse;
    apb(1, ADDR_FEATURE_ENH, 0);
    repeat (3) @(posedge clk_sys);
    chk("boost cut", d, loop_current_limit_ma);
    for (i = 0; i < 4; i++) begin
      apb(1, ADDR_FEATURE_ENH, i[0] ? 32'h04 : 32'h0);
      loop_current_closed <= i[1];
      loop_voltage_closed <= !i[1];
      repeat (3) @(posedge clk_sys);
      chk("closure", i[0] ? !i[1] : i[1], loop_closed);
    end
    apb(1, ADDR_FEATURE_ENH, 32'h08);
    battery_high_request <= 0;
    repeat (2) @(posedge clk_sys);
    chk("batt low", 0, battery_high_select);
    battery_high_request <= 1;
    repeat (2) @(posedge clk_sys);
    chk("batt high", 1, battery_high_select);
    for (i = 0; i < 4; i++) begin
      apb(1, ADDR_FEATURE_ENH, i[0] ? 32'h40 : 32'h0);
      apb(1, ADDR_LINE_CTRL, i[1] ? 32'h40 : 32'h0);
      gap;
      gap;
      chk("fast", i == 3, tone_fast_mode);
      chk("fskset", i == 3, tone_osc_one_fsk_set);
      chk("period", (i == 3) ? 3 : 8, c);
      apb(0, ADDR_STATUS, 0);
      chk("status", i == 3, rdv[BIT_ST_FAST]);
    end
    give_verdict;
  end
endmodule : eec_enhance_ctrl_bench
